// ===== rtl/ast_top.sv
// Purpose: Sample and convert sequencing of the converter, with its
//          control registers on APB.
// Assumes: Converter core and trigger sources run on clock; only the
//          interrupt pin is asynchronous.
// Notes:   APB answers one cycle after the access phase opens.
//
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "ast_regs.svh"
module ast_top
    import ast_pkg::*;
(
    // Clock and reset.
    input wire logic clock,
    input wire logic reset_n,
    // APB slave.
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Trigger sources.
    input wire logic external_interrupt_zero_pin,
    input wire logic timer_three_event,
    input wire logic timer_five_event,
    input wire logic pwm_special_event,
    input wire logic charge_time_event,
    input wire logic [2:0] pwm_gen_trigger,
    input wire logic [3:0] trigger_generator_output,
    // Converter core.
    input wire logic conv_done,
    output logic conv_start,
    output logic [1:0] conv_channel,
    output logic [3:0] sample_enable
);

    ast_main_type r; // Registered state.
    ast_main_type n; // Next state.
    logic ext_pin_edge; // Synchronised pin transition.
    logic trig_hit; // Selected event present.
    logic trig_reserved; // Reserved code selected.
    logic auto_hit; // Sample time elapsed.
    logic manual; // Manual trigger mode.
    logic auto_mode; // Internal counter mode.
    logic sim_on; // Simultaneous sampling in force.
    logic [1:0] last_chan; // Highest channel in use.
    logic [4:0] stime_eff; // Sample time, at least one.
    logic wr_ok; // Write takes effect now.
    logic [1:0] wr_sel; // Decoded write register.
    logic [31:0] rd_data; // Read word.

    // Maps an address to a register, three meaning unmapped.
    function automatic logic [1:0] reg_index(input logic [11:0] addr);
        case (addr)
            `AST_CTRL_OFFSET: reg_index = 2'h0;
            `AST_CFG_OFFSET: reg_index = 2'h1;
            `AST_STAT_OFFSET: reg_index = 2'h2;
            default: reg_index = 2'h3;
        endcase
    endfunction

    // Last channel index for a channel count code.
    function automatic logic [1:0] last_of(input logic [1:0] cnt_code);
        if (cnt_code[1]) begin
            last_of = 2'h3;
        end else begin
            last_of = {1'b0, cnt_code[0]};
        end
    endfunction

    // Sample enables for a phase: a group or a single channel.
    function automatic logic [3:0] chan_mask(input logic sim,
                                             input logic [1:0] last,
                                             input logic [1:0] idx);
        chan_mask = 4'h0;
        for (int i = 0; i < 4; i++) begin
            if (sim) begin
                chan_mask[i] = (2'(i) <= last);
            end else begin
                chan_mask[i] = (2'(i) == idx);
            end
        end
    endfunction

    // Filters the interrupt pin into one pulse per rising transition.
    ast_pin_sync ast_pin_sync_inst (
        .clock(clock),
        .reset_n(reset_n),
        .pin_in(external_interrupt_zero_pin),
        .rise_pulse(ext_pin_edge)
    );

    // Selects the event that ends sampling.
    ast_trig_mux ast_trig_mux_inst (
        .trig_group(r.trig_group),
        .trig_code(r.trig_code),
        .ext_pin_edge(ext_pin_edge),
        .timer_three_event(timer_three_event),
        .timer_five_event(timer_five_event),
        .pwm_special_event(pwm_special_event),
        .charge_time_event(charge_time_event),
        .auto_hit(auto_hit),
        .pwm_gen_trigger(pwm_gen_trigger),
        .trigger_generator_output(trigger_generator_output),
        .trig_hit(trig_hit),
        .trig_reserved(trig_reserved)
    );

    // Mode decode shared by the sequencer and the read mux.
    always_comb begin
        manual = !r.trig_group && r.trig_code == `AST_CODE_MANUAL;
        auto_mode = !r.trig_group && r.trig_code == `AST_CODE_AUTO;
        sim_on = r.sim_sel && !r.twelve_bit;
        last_chan = last_of(r.chan_count);
        stime_eff = (r.sample_control_bit_time == 5'h00) ? 5'h01 : r.sample_control_bit_time;
        auto_hit = r.state == AST_SAMPLE &&
                   r.sample_control_bit_cnt >= stime_eff - 5'h01;
        wr_ok = psel && penable && r.pready && pwrite && !r.pslverr;
        wr_sel = reg_index(paddr);
    end

    // Read word of the addressed register.
    always_comb begin
        rd_data = 32'h0000_0000;
        case (reg_index(paddr))
            2'h0: begin
                rd_data[`AST_CTRL_CODE_MSB:`AST_CTRL_CODE_LSB] =
                    r.trig_code;
                rd_data[`AST_CTRL_GROUP_BIT] = r.trig_group;
                rd_data[`AST_CTRL_SIM_BIT] = sim_on;
                rd_data[`AST_CTRL_AUTO_BIT] = r.auto_start;
                rd_data[`AST_CTRL_SAMPLE_BIT] = (r.state == AST_SAMPLE);
                rd_data[`AST_CTRL_DONE_BIT] = r.done;
            end
            2'h1: begin
                rd_data[`AST_CFG_CHAN_MSB:`AST_CFG_CHAN_LSB] =
                    r.chan_count;
                rd_data[`AST_CFG_TWELVE_BIT] = r.twelve_bit;
                rd_data[`AST_CFG_STIME_MSB:`AST_CFG_STIME_LSB] =
                    r.sample_control_bit_time;
            end
            2'h2: begin
                rd_data[1:0] = r.state;
                rd_data[3:2] = r.chan_idx;
                rd_data[5:4] = r.conv_chan;
                rd_data[6] = trig_reserved;
            end
            default: begin
                rd_data = 32'h0000_0000;
            end
        endcase
    end

    // Bus handshake, register writes and the sample sequence.
    always_comb begin
        n = r;
        n.conv_start = 1'b0;
        // Access phase: answer next cycle, then release.
        if (psel && penable && !r.pready) begin
            n.pready = 1'b1;
            n.pslverr = (reg_index(paddr) == 2'h3);
            n.prdata = rd_data;
        end else begin
            n.pready = 1'b0;
            n.pslverr = 1'b0;
        end
        // Configuration fields take effect on the completing edge.
        if (wr_ok && wr_sel == 2'h0) begin
            n.trig_code = pwdata[`AST_CTRL_CODE_MSB:`AST_CTRL_CODE_LSB];
            n.trig_group = pwdata[`AST_CTRL_GROUP_BIT];
            n.sim_sel = pwdata[`AST_CTRL_SIM_BIT] && !r.twelve_bit;
            n.auto_start = pwdata[`AST_CTRL_AUTO_BIT];
            // Software may only clear the completion flag.
            if (!pwdata[`AST_CTRL_DONE_BIT]) begin
                n.done = 1'b0;
            end
        end
        if (wr_ok && wr_sel == 2'h1) begin
            n.chan_count = pwdata[`AST_CFG_CHAN_MSB:`AST_CFG_CHAN_LSB];
            n.twelve_bit = pwdata[`AST_CFG_TWELVE_BIT];
            n.sample_control_bit_time = pwdata[`AST_CFG_STIME_MSB:`AST_CFG_STIME_LSB];
            n.chan_idx = 2'h0;
            // Entering twelve-bit mode drops simultaneous sampling.
            if (pwdata[`AST_CFG_TWELVE_BIT]) begin
                n.sim_sel = 1'b0;
            end
        end
        // Sequencer.
        case (r.state)
            AST_HOLD: begin
                // Auto-start or a software set opens sampling.
                if (r.auto_start || (wr_ok && wr_sel == 2'h0 &&
                    pwdata[`AST_CTRL_SAMPLE_BIT])) begin
                    n.state = AST_SAMPLE;
                    n.sample_control_bit_cnt = 5'h00;
                end
            end
            AST_SAMPLE: begin
                if (r.sample_control_bit_cnt != 5'h1F) begin
                    n.sample_control_bit_cnt = r.sample_control_bit_cnt + 5'h01;
                end
                // Manual: the software clear is the trigger.
                if (manual && wr_ok && wr_sel == 2'h0 &&
                    !pwdata[`AST_CTRL_SAMPLE_BIT]) begin
                    n.state = AST_CONVERT;
                end else if (!manual && trig_hit) begin
                    n.state = AST_CONVERT;
                end else if (wr_ok && wr_sel == 2'h0 &&
                             !pwdata[`AST_CTRL_SAMPLE_BIT]) begin
                    // A software clear outside manual aborts sampling.
                    n.state = AST_HOLD;
                end
                if (n.state == AST_CONVERT) begin
                    n.conv_start = 1'b1;
                    n.done = 1'b0;
                    n.conv_chan = sim_on ? 2'h0 : r.chan_idx;
                end
            end
            AST_CONVERT: begin
                if (conv_done) begin
                    if (sim_on && r.conv_chan != last_chan) begin
                        // Held channels convert one after another.
                        n.conv_chan = r.conv_chan + 2'h1;
                        n.conv_start = 1'b1;
                    end else begin
                        // Sequence step finished.
                        if (sim_on || r.chan_idx >= last_chan) begin
                            n.done = 1'b1;
                            n.chan_idx = 2'h0;
                        end else begin
                            n.chan_idx = r.chan_idx + 2'h1;
                        end
                        n.state = r.auto_start ? AST_SAMPLE : AST_HOLD;
                        n.sample_control_bit_cnt = 5'h00;
                    end
                end
            end
            default: begin
                n.state = AST_HOLD;
            end
        endcase
        // Mask from the next fields, so it matches them once registered.
        n.sample_en = (n.state == AST_SAMPLE) ?
            chan_mask(n.sim_sel && !n.twelve_bit, last_of(n.chan_count),
                      n.chan_idx) : 4'h0;
    end

    // Registers the whole state; reset loads constants only.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            r <= '0;
            r.sample_control_bit_time <= `AST_STIME_RESET;
        end else begin
            r <= n;
        end
    end

    // Outputs come straight from flip-flops.
    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign conv_start = r.conv_start;
    assign conv_channel = r.conv_chan;
    assign sample_enable = r.sample_en;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    logic ctrl_wr; // Control word write completes now.
    assign ctrl_wr = wr_ok && wr_sel == 2'h0;

    code_field_a: assert property (ctrl_wr |=>
        r.trig_code == $past(pwdata[7:5]) &&
        r.trig_group == $past(pwdata[4]))
        else $error("Trigger code or group not stored.");
    manual_hold_a: assert property (manual && !ctrl_wr &&
        r.state == AST_SAMPLE |=> !conv_start)
        else $error("Manual mode converted without software clear.");
    pin_edge_a: assert property (r.state == AST_SAMPLE &&
        !r.trig_group && r.trig_code == 3'h1 && ext_pin_edge && !ctrl_wr
        |=> conv_start && r.state == AST_CONVERT)
        else $error("Pin transition did not start conversion.");
    timer_event_a: assert property (r.state == AST_SAMPLE &&
        !r.trig_group && !ctrl_wr && ((r.trig_code == 3'h2 &&
        timer_three_event) || (r.trig_code == 3'h4 && timer_five_event))
        |=> conv_start)
        else $error("Timer compare did not start conversion.");
    pwm_special_a: assert property (r.state == AST_SAMPLE &&
        !r.trig_group && r.trig_code == 3'h3 && pwm_special_event &&
        !ctrl_wr |=> conv_start)
        else $error("PWM special event ignored.");
    charge_event_a: assert property (r.state == AST_SAMPLE &&
        !r.trig_group && r.trig_code == 3'h6 && charge_time_event && !ctrl_wr
        |=> conv_start)
        else $error("Charge-time event ignored.");
    auto_convert_a: assert property ($rose(r.state == AST_SAMPLE) &&
        auto_mode && r.sample_control_bit_time == 5'h03 && !ctrl_wr ##1 !ctrl_wr [*2]
        |=> conv_start)
        else $error("Auto-convert missed its sample time.");
    pwm_gen_a: assert property (r.state == AST_SAMPLE &&
        r.trig_group && r.trig_code <= 3'h2 && !ctrl_wr &&
        pwm_gen_trigger[r.trig_code[1:0]] |=> conv_start)
        else $error("PWM generator trigger ignored.");
    ptg_out_a: assert property (r.state == AST_SAMPLE &&
        r.trig_group && r.trig_code inside {[3'h3:3'h6]} && !ctrl_wr &&
        trigger_generator_output[2'(r.trig_code - 3'h3)]
        |=> conv_start)
        else $error("Trigger generator output ignored.");
    simul_mask_a: assert property (r.state == AST_SAMPLE &&
        sim_on |-> sample_enable == (r.chan_count[1] ? 4'hF :
        (r.chan_count[0] ? 4'h3 : 4'h1)))
        else $error("Simultaneous sample mask wrong.");
    seq_onehot_a: assert property (r.state == AST_SAMPLE &&
        !sim_on |-> $onehot(sample_enable))
        else $error("Sequential mode sampled several channels.");
    twelve_bit_a: assert property (r.twelve_bit |-> !sim_on &&
        !rd_data[3] || reg_index(paddr) != 2'h0)
        else $error("Simultaneous bit visible in twelve-bit mode.");
    auto_start_a: assert property (r.state == AST_CONVERT &&
        conv_done && r.auto_start && !(sim_on && r.conv_chan != last_chan)
        |=> r.state == AST_SAMPLE)
        else $error("Auto-start did not resume sampling.");
    hold_wait_a: assert property (r.state == AST_HOLD && !r.auto_start &&
        !ctrl_wr |=> r.state == AST_HOLD)
        else $error("Sampling began without software set.");
    hw_clear_a: assert property (r.state == AST_SAMPLE && !manual &&
        trig_hit |=> r.state == AST_CONVERT && conv_start)
        else $error("Trigger did not clear the sample bit.");
    reserved_a: assert property (r.state == AST_SAMPLE &&
        trig_reserved && !ctrl_wr |=> r.state == AST_SAMPLE)
        else $error("Reserved code left sampling.");

    seq_done_c: cover property (r.state == AST_CONVERT && conv_done
        ##1 r.done);
    simul_four_c: cover property (sim_on && r.chan_count[1] &&
        r.state == AST_CONVERT ##[1:40] r.conv_chan == 2'h3);
    auto_loop_c: cover property (auto_mode && r.auto_start && conv_start
        ##[1:80] conv_start);
    bus_error_c: cover property (pslverr && pready);

endmodule
`default_nettype wire

// ===== shared/ast_regs.svh
// Purpose: Register offsets, field positions and reset values of the
//          converter sample and trigger control block.
// Assumes: 32-bit APB data, one aligned word per register.
// Notes:   Offsets, control and configuration fields and reset values live here as macros; status fields do not.
//
// Overview of operation
// - Trigger code bits 7-5, group bit 4.
// - Group 0, code 000: software clear converts.
// - Group 0, code 001: interrupt pin edge converts.
// - Group 0: 010 timer three, 100 timer five.
// - Group 0, code 011: PWM special event converts.
// - Group 0, code 110: charge-time unit converts.
// - Group 0, code 111 auto-convert; 101 reserved.
// - Group 1, codes 000-010: PWM generators 1-3.
// - Group 1, codes 011-110: generator outputs 12-15.
// - Simultaneous: four channels, channels zero, one, or channel zero alone.
// - Not simultaneous: channels sampled one at a time.
// - Twelve-bit mode: simultaneous bit reads as zero.
// - Auto-start sets sample bit after conversion completes.
// - Without auto-start, software sets the sample bit.
// - Non-manual trigger clears sample bit, starts conversion.
`ifndef AST_REGS_SVH
`define AST_REGS_SVH

// Register byte offsets.
`define AST_CTRL_OFFSET 12'h000
`define AST_CFG_OFFSET 12'h004
`define AST_STAT_OFFSET 12'h008

// Control word fields.
`define AST_CTRL_DONE_BIT 0
`define AST_CTRL_SAMPLE_BIT 1
`define AST_CTRL_AUTO_BIT 2
`define AST_CTRL_SIM_BIT 3
`define AST_CTRL_GROUP_BIT 4
`define AST_CTRL_CODE_LSB 5
`define AST_CTRL_CODE_MSB 7

// Configuration word fields.
`define AST_CFG_CHAN_LSB 0
`define AST_CFG_CHAN_MSB 1
`define AST_CFG_TWELVE_BIT 2
`define AST_CFG_STIME_LSB 8
`define AST_CFG_STIME_MSB 12

// Trigger codes with a meaning of their own.
`define AST_CODE_MANUAL 3'h0
`define AST_CODE_AUTO 3'h7

// Reset values.
`define AST_CTRL_RESET 32'h0000_0000
`define AST_STIME_RESET 5'h01

`endif

// ===== shared/ast_pkg.sv
// Purpose: Types of the converter sample and trigger control block.
// Assumes: Included constants from ast_regs.svh.
// Notes:   State of the top and pin synchroniser modules is one packed struct each.
package ast_pkg;

    // Phases of the sample and hold sequence.
    typedef enum logic [1:0] {
        AST_HOLD,
        AST_SAMPLE,
        AST_CONVERT
    } ast_state_type;

    // All state of the pin synchroniser.
    typedef struct packed {
        logic [2:0] chain;
        logic level;
        logic rise;
    } ast_sync_type;

    // All state of the top module.
    typedef struct packed {
        ast_state_type state;
        logic [2:0] trig_code;
        logic trig_group;
        logic sim_sel;
        logic auto_start;
        logic done;
        logic [1:0] chan_count;
        logic twelve_bit;
        logic [4:0] sample_control_bit_time;
        logic [4:0] sample_control_bit_cnt;
        logic [1:0] chan_idx;
        logic [1:0] conv_chan;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic conv_start;
        logic [3:0] sample_en;
    } ast_main_type;

endpackage

// ===== rtl/ast_pin_sync.sv
// Purpose: Brings the external interrupt pin into the clock domain and
//          flags each rising transition once.
// Assumes: The pin is asynchronous to clock.
// Notes:   A change counts once the second and third stages agree.
`timescale 1ns/10ps
`default_nettype none
module ast_pin_sync
    import ast_pkg::*;
(
    // Clock and reset.
    input wire logic clock,
    input wire logic reset_n,
    // Raw pin and its edge flag.
    input wire logic pin_in,
    output logic rise_pulse
);

    ast_sync_type sync_reg; // Registered state.
    ast_sync_type sync_next; // Next state.

    // Shifts the chain and updates the filtered level.
    always_comb begin
        sync_next = sync_reg;
        sync_next.chain = {sync_reg.chain[1:0], pin_in};
        sync_next.rise = 1'b0;
        // Stages two and three agree on a new level.
        if (sync_reg.chain[1] == sync_reg.chain[2] &&
            sync_reg.chain[2] != sync_reg.level) begin
            sync_next.level = sync_reg.chain[2];
            sync_next.rise = sync_reg.chain[2];
        end
    end

    // Registers the state; reset loads constants only.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            sync_reg <= '0;
        end else begin
            sync_reg <= sync_next;
        end
    end

    assign rise_pulse = sync_reg.rise;

endmodule
`default_nettype wire

// ===== rtl/ast_trig_mux.sv
// Purpose: Picks the event that ends sampling from the group and code.
// Assumes: All events are one-cycle pulses on clock.
// Notes:   Reserved codes select nothing and are flagged.
`timescale 1ns/10ps
`default_nettype none
module ast_trig_mux
    import ast_pkg::*;
(
    // Selection.
    input wire logic trig_group,
    input wire logic [2:0] trig_code,
    // Group zero events.
    input wire logic ext_pin_edge,
    input wire logic timer_three_event,
    input wire logic timer_five_event,
    input wire logic pwm_special_event,
    input wire logic charge_time_event,
    input wire logic auto_hit,
    // Group one events.
    input wire logic [2:0] pwm_gen_trigger,
    input wire logic [3:0] trigger_generator_output,
    // Result.
    output logic trig_hit,
    output logic trig_reserved
);

    // Decodes one code of either group to its event.
    function automatic logic pick_zero(input logic [2:0] code,
                                       input logic [7:0] ev);
        pick_zero = ev[code];
    endfunction

    logic [7:0] group_zero; // Events by group zero code.
    logic [7:0] group_one; // Events by group one code.

    // Lays the events out by code and selects one.
    always_comb begin
        group_zero = {auto_hit, charge_time_event, 1'b0, timer_five_event,
                      pwm_special_event, timer_three_event, ext_pin_edge,
                      1'b0};
        group_one = {1'b0, trigger_generator_output,
                     pwm_gen_trigger};
        // The pick ignores any event on a reserved code.
        if (trig_group) begin
            trig_hit = pick_zero(trig_code, group_one);
            trig_reserved = (trig_code == 3'h7);
        end else begin
            trig_hit = pick_zero(trig_code, group_zero);
            trig_reserved = (trig_code == 3'h5);
        end
    end

endmodule
`default_nettype wire

// ===== verification/ast_core_model.sv
// Purpose: Behavioural converter core facing the sample control block.
// Assumes: Start and done are one-cycle pulses on clock.
// Notes:   Each start is answered by exactly one done, LAT cycles on.
`timescale 1ns/10ps
`default_nettype none
module ast_core_model #(
    parameter int LAT = 3
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic reset_n,
    // Converter handshake.
    input wire logic conv_start,
    output logic conv_done
);
    // Cycles left in the running conversion.
    int cnt;

    // A start loads the counter; done pulses when it runs out.
    always @(posedge clock) begin
        conv_done <= 1'h0;
        if (!reset_n) begin
            cnt <= 0;
        end else if (conv_start) begin
            cnt <= LAT;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
            conv_done <= (cnt == 1);
        end
    end
endmodule
`default_nettype wire

// ===== verification/ast_top_tb.sv
// Purpose: Self-checking bench of the sample and trigger control block.
// Assumes: APB answers after one wait; the core model closes each start.
// Notes:   Every trigger code of both groups is exercised in turn.
`timescale 1ns/10ps
`default_nettype none
module ast_top_tb;
    logic clock = 1'h0;
    logic reset_n = 1'h0;
    logic [11:0] paddr = 12'h0;
    logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd, ctl;
    logic pready, pslverr, conv_done, conv_start;
    logic pin = 1'h0, t3 = 1'h0, t5 = 1'h0, pse = 1'h0, cte = 1'h0;
    logic [2:0] pg = 3'h0;
    logic [3:0] tg = 4'h0, sample_enable;
    logic [1:0] conv_channel;
    int bad_count = 0, checks_done = 0, starts = 0, s0 = 0;

    // The clock toggles every half period of 2.5 ns.
    always #2.5 clock = ~clock;

    // Counts conversion starts issued by the block.
    always @(posedge clock) if (conv_start === 1'h1) starts <= starts + 1;

    ast_top ast_top_inst (.clock(clock), .reset_n(reset_n), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .external_interrupt_zero_pin(pin), .timer_three_event(t3),
        .timer_five_event(t5), .pwm_special_event(pse),
        .charge_time_event(cte),
        .pwm_gen_trigger(pg), .trigger_generator_output(tg),
        .conv_done(conv_done), .conv_start(conv_start),
        .conv_channel(conv_channel), .sample_enable(sample_enable));

    ast_core_model ast_core_model_inst (.clock(clock), .reset_n(reset_n),
        .conv_start(conv_start), .conv_done(conv_done));

    // One APB transfer; holds the request until pready is sampled high.
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'h1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'h1;
        do @(posedge clock); while (pready !== 1'h1 && ++n < 20);
        if (pready !== 1'h1) begin
            bad_count++;
            $display("Error %0t: no pready", $time);
        end
        rd = prdata;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    // Compares one word and reports a mismatch.
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("Error %0t: got %h want %h", $time, g, e);
        end
    endtask

    // Pulses the event of one group and code; the pin is held longer.
    task automatic fire(input logic g, input logic [2:0] c);
        @(posedge clock);
        if (g) begin
            if (c < 3) pg[c[1:0]] <= 1'h1;
            else tg[2'(c - 3'h3)] <= 1'h1;
        end else begin
            case (c)
                3'h1: pin <= 1'h1;
                3'h2: t3 <= 1'h1;
                3'h3: pse <= 1'h1;
                3'h4: t5 <= 1'h1;
                3'h6: cte <= 1'h1;
                default: ;
            endcase
        end
        @(posedge clock);
        {pg, tg, t3, t5, pse, cte} <= 11'h0;
        repeat (6) @(posedge clock);
        pin <= 1'h0;
    endtask

    // Prints the verdict and ends the run.
    task automatic close_out;
        if (bad_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // Cuts a hang short.
    initial begin
        repeat (20000) @(posedge clock);
        bad_count++;
        close_out;
    end

    // Main sequence of tests.
    initial begin
        repeat (5) @(posedge clock);
        reset_n <= 1'h1;
        apb(1'h0, 12'h000, 32'h0);
        chk(rd, 32'h0);
        apb(1'h0, 12'h00C, 32'h0);
        chk(32'(pslverr), 32'h1);
        for (int g = 0; g < 2; g++) begin
            for (int c = 0; c < 7; c++) begin
                if (g == 0 && (c == 0 || c == 5)) continue;
                ctl = {24'h0, 3'(c), 1'(g), 4'h2};
                apb(1'h1, 12'h000, ctl);
                fire(!g, 3'(c));
                apb(1'h0, 12'h008, 32'h0);
                chk(32'(rd[1:0]), 32'h1);
                fire(1'(g), 3'(c));
                repeat (8) @(posedge clock);
                apb(1'h0, 12'h000, 32'h0);
                chk(rd, ctl ^ 32'h3);
            end
        end
        apb(1'h1, 12'h000, 32'h2);
        apb(1'h1, 12'h000, 32'h0);
        repeat (8) @(posedge clock);
        apb(1'h0, 12'h000, 32'h0);
        chk(rd, 32'h1);
        for (int g = 0; g < 2; g++) begin
            apb(1'h1, 12'h000, {24'h0, (g ? 4'hF : 4'hA), 4'h2});
            for (int c = 0; c < 7; c++) fire(1'(g), 3'(c));
            apb(1'h0, 12'h008, 32'h0);
            chk(32'({rd[6], rd[1:0]}), 32'h5);
            apb(1'h1, 12'h000, 32'h0);
        end
        apb(1'h1, 12'h004, 32'h0300);
        apb(1'h1, 12'h000, 32'hE2);
        repeat (12) @(posedge clock);
        apb(1'h0, 12'h000, 32'h0);
        chk(rd, 32'hE1);
        apb(1'h1, 12'h004, 32'h0402);
        apb(1'h1, 12'h000, 32'h4A);
        @(posedge clock);
        chk(32'(sample_enable), 32'hF);
        s0 = starts;
        fire(1'h0, 3'h2);
        repeat (20) @(posedge clock);
        chk(32'(starts - s0), 32'h4);
        chk(32'(conv_channel), 32'h3);
        apb(1'h1, 12'h000, 32'h42);
        fire(1'h0, 3'h2);
        repeat (8) @(posedge clock);
        apb(1'h0, 12'h008, 32'h0);
        chk(32'(rd[3:0]), 32'h4);
        apb(1'h1, 12'h004, 32'h0406);
        apb(1'h1, 12'h000, 32'h48);
        apb(1'h0, 12'h000, 32'h0);
        chk(32'(rd[3]), 32'h0);
        apb(1'h1, 12'h004, 32'h0400);
        apb(1'h1, 12'h000, 32'h46);
        fire(1'h0, 3'h2);
        repeat (8) @(posedge clock);
        apb(1'h0, 12'h000, 32'h0);
        chk(rd, 32'h47);
        close_out;
    end
endmodule
`default_nettype wire
